// >>> pkg/cbt_pkg.sv
// Constants and carrier types for the two-channel circuit-breaker control.
// Assumes a 25 MHz logic clock and a byte-wide internal register port.
package cbt_pkg;

  // Register offsets
  localparam logic [7:0] CBT_OFF_CODE0 = 8'h2e;
  localparam logic [7:0] CBT_OFF_CODE1 = 8'h2f;
  localparam logic [7:0] CBT_OFF_RATIO = 8'h30;
  localparam logic [7:0] CBT_OFF_RANGE = 8'h33;

  // Reset values
  localparam logic [7:0] CBT_CODE_RST  = 8'hbf;
  localparam logic [7:0] CBT_RATIO_RST = 8'h0f;

  // Field layout: two bits per channel in ratio and range registers
  localparam int CBT_FLD_W   = 2;
  localparam int CBT_FLD_CH1 = 2;

  // Range codes and full-scale values in 10 uV units
  localparam logic [1:0]  CBT_RNG_100 = 2'h0;
  localparam logic [1:0]  CBT_RNG_50  = 2'h1;
  localparam logic [1:0]  CBT_RNG_25  = 2'h2;
  localparam logic [13:0] CBT_FS_100  = 14'h2710;
  localparam logic [13:0] CBT_FS_50   = 14'h1388;
  localparam logic [13:0] CBT_FS_25   = 14'h09c4;

  // Ratio percentages for codes 00..11
  localparam logic [7:0] CBT_PCT_125 = 8'h7d;
  localparam logic [7:0] CBT_PCT_150 = 8'h96;
  localparam logic [7:0] CBT_PCT_175 = 8'haf;
  localparam logic [7:0] CBT_PCT_200 = 8'hc8;
  localparam logic [7:0] CBT_PCT_UNIT = 8'h64;

  // Code scale and lowest usable code (40 percent of 255)
  localparam logic [7:0] CBT_CODE_FULL = 8'hff;
  localparam logic [7:0] CBT_CODE_MIN  = 8'h66;

  // Three-level range pin as sensed: low, high, open
  localparam logic [1:0] CBT_PIN_LOW  = 2'h0;
  localparam logic [1:0] CBT_PIN_HIGH = 2'h1;

  // Slow path: leak per cycle and overdrive budget before shutdown
  localparam logic [15:0] CBT_SLOW_LEAK   = 16'h0001;
  localparam logic [15:0] CBT_SLOW_BUDGET = 16'h4000;

  // Cycles after reset release before the range strap is caught
  localparam logic [1:0] CBT_STRAP_WAIT = 2'h2;

  // Register write request
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cbt_reg_req_t;

  // Per-channel threshold pair sent to the comparator DACs
  typedef struct packed {
    logic [13:0] fast;
    logic [13:0] slow;
  } cbt_thresh_t;

endpackage

// >>> core/cbt_breaker.sv
// Two-channel overcurrent breaker: thresholds, trip logic, gate and fault.
// Assumes comparator outputs and range pins are asynchronous; sense level
// and channel enables come from logic on clk.
//
// Notes on behaviour
// - Gate stays on while sense is below both trip thresholds.
// - Gate turns off when the fast threshold is exceeded, or when slow overdrive reaches the budget.
// - Fast threshold comes from an 8-bit code within the selected range.
// - Full-scale range is 25, 50 or 100 mV per channel.
// - Usable fast threshold spans 40 to 100 percent of full scale.
// - Ratio field per channel: 125/150/175/200 percent, bits 1:0 and 3:2.
// - Ratio register resets to 0x0f, both channels at 200 percent.
// - Slow threshold is fast threshold divided by the ratio.
// - Range loads from the three-level pin, software may overwrite.
// - Range, code and ratio changes apply live, no restart.
// - Slow path rejects small short overdrive; fast path acts at once.
// - A trip shutdown asserts the channel's open-drain fault output.
// - Pin low gives range 10, high gives 01, open gives 00.
// - Each threshold code register resets to 0xbf.
`timescale 1ns/10ps
module cbt_breaker #(
  parameter int          NCH         = 2,
  parameter logic [15:0] SLOW_BUDGET = cbt_pkg::CBT_SLOW_BUDGET
) (
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  // Register port
  input  wire cbt_pkg::cbt_reg_req_t         reg_req,
  input  wire logic [7:0]                    reg_raddr,
  output logic [7:0]                         reg_rdata,
  // Channel control and sense level in 10 uV units
  input  wire logic [NCH-1:0]                chan_en,
  input  wire logic [NCH-1:0][13:0]          sense_level,
  // Analog comparators and range pins, asynchronous
  input  wire logic [NCH-1:0]                fast_cmp_async,
  input  wire logic [NCH-1:0]                slow_cmp_async,
  input  wire logic [NCH-1:0][1:0]           range_select_pin,
  // Threshold DAC settings
  output cbt_pkg::cbt_thresh_t [NCH-1:0]     thresh,
  // Gate drive and open-drain fault pin
  output logic [NCH-1:0]                     gate_on,
  input  wire logic [NCH-1:0]                fault_in,
  output logic [NCH-1:0]                     fault_out,
  output logic [NCH-1:0]                     fault_oe_n
);
  import cbt_pkg::*;

  // All checks run on clk and stay quiet while reset is held
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Full-scale value of a range code; the illegal code 11 falls to 100 mV
  function automatic logic [13:0] fs_of(input logic [1:0] rng);
    unique case (rng)
      CBT_RNG_25: fs_of = CBT_FS_25;
      CBT_RNG_50: fs_of = CBT_FS_50;
      default:    fs_of = CBT_FS_100;
    endcase
  endfunction

  // Fast threshold = code / 255 of full scale, code clamped to the span
  function automatic logic [13:0] fast_of(input logic [7:0] code,
                                          input logic [1:0] rng);
    logic [7:0]  c;
    logic [21:0] p;
    c = (code < CBT_CODE_MIN) ? CBT_CODE_MIN : code;
    p = 22'(c) * 22'(fs_of(rng));
    fast_of = 14'(p / 22'(CBT_CODE_FULL));
  endfunction

  // Slow threshold = fast * 100 / ratio percent
  function automatic logic [13:0] slow_of(input logic [13:0] fast,
                                          input logic [1:0]  ratio);
    logic [7:0]  pct;
    logic [20:0] p;
    unique case (ratio)
      2'h0: pct = CBT_PCT_125;
      2'h1: pct = CBT_PCT_150;
      2'h2: pct = CBT_PCT_175;
      2'h3: pct = CBT_PCT_200;
    endcase
    p = 21'(fast) * 21'(CBT_PCT_UNIT);
    slow_of = 14'(p / 21'(pct));
  endfunction

  // Register storage
  logic [NCH-1:0][7:0] code;
  logic [7:0]          ratio_reg;
  logic [3:0]          range_reg;
  logic [1:0]          strap_cnt;

  // Synchronisers and per-channel state
  logic [NCH-1:0]      fast_m, fast_s, slow_m, slow_s;
  logic [NCH-1:0][1:0] pin_m, pin_s;
  logic [NCH-1:0]      tripped;
  logic [NCH-1:0][15:0] slow_acc;

  // Register decode
  wire wr_code0 = reg_req.wr && reg_req.addr == CBT_OFF_CODE0;
  wire wr_code1 = reg_req.wr && reg_req.addr == CBT_OFF_CODE1;
  wire wr_ratio = reg_req.wr && reg_req.addr == CBT_OFF_RATIO;
  wire wr_range = reg_req.wr && reg_req.addr == CBT_OFF_RANGE;
  wire strap_ld = strap_cnt == CBT_STRAP_WAIT;

  // Read mux; reserved bits and unmapped offsets read as zero
  wire [7:0] rd_mux =
    (reg_raddr == CBT_OFF_CODE0) ? code[0] :
    (reg_raddr == CBT_OFF_CODE1) ? code[1] :
    (reg_raddr == CBT_OFF_RATIO) ? {4'h0, ratio_reg[3:0]} :
    (reg_raddr == CBT_OFF_RANGE) ? {4'h0, range_reg} : 8'h00;

  // Pin level to range code
  function automatic logic [1:0] pin_to_rng(input logic [1:0] lvl);
    unique case (lvl)
      CBT_PIN_LOW:  pin_to_rng = CBT_RNG_25;
      CBT_PIN_HIGH: pin_to_rng = CBT_RNG_50;
      default:      pin_to_rng = CBT_RNG_100;
    endcase
  endfunction

  wire [3:0] strap_rng = {pin_to_rng(pin_s[1]), pin_to_rng(pin_s[0])};

  // Threshold codes and ratio; writes take effect on the next cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      code[0]   <= CBT_CODE_RST;
      code[1]   <= CBT_CODE_RST;
      ratio_reg <= CBT_RATIO_RST;
    end else begin
      if (wr_code0) code[0] <= reg_req.wdata;
      if (wr_code1) code[1] <= reg_req.wdata;
      if (wr_ratio) ratio_reg <= {4'h0, reg_req.wdata[3:0]};
    end
  end

  // Range: strap caught once the pin synchroniser has settled after reset,
  // so a write in that same cycle still wins
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      range_reg <= 4'h0;
      strap_cnt <= 2'h0;
    end else begin
      if (strap_cnt != 2'h3) strap_cnt <= strap_cnt + 2'h1;
      if (wr_range) range_reg <= reg_req.wdata[3:0];
      else if (strap_ld) range_reg <= strap_rng;
    end
  end

  // Registered read data
  always_ff @(posedge clk) begin
    if (!rst_n) reg_rdata <= 8'h00;
    else reg_rdata <= rd_mux;
  end

  // Two-flop synchronisers for comparators and range pins
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fast_m <= '0;
      fast_s <= '0;
      slow_m <= '0;
      slow_s <= '0;
      pin_m  <= '0;
      pin_s  <= '0;
    end else begin
      fast_m <= fast_cmp_async;
      fast_s <= fast_m;
      slow_m <= slow_cmp_async;
      slow_s <= slow_m;
      pin_m  <= range_select_pin;
      pin_s  <= pin_m;
    end
  end

  // Per-channel thresholds and trip logic
  for (genvar ch = 0; ch < NCH; ch++) begin : g_ch
    wire [1:0]  rng_c   = range_reg[ch*CBT_FLD_CH1 +: CBT_FLD_W];
    wire [1:0]  rat_c   = ratio_reg[ch*CBT_FLD_CH1 +: CBT_FLD_W];
    wire [13:0] fast_th = fast_of(code[ch], rng_c);
    wire [13:0] slow_th = slow_of(fast_th, rat_c);
    // Overdrive weight grows with the excess, so large faults trip sooner
    wire        over    = slow_s[ch] && sense_level[ch] > thresh[ch].slow;
    wire [15:0] excess  = over ? 16'(sense_level[ch] - thresh[ch].slow)
                               : 16'h0000;
    wire [16:0] acc_sum = 17'(slow_acc[ch]) + 17'(excess);
    wire        slow_hit = over && acc_sum >= 17'(SLOW_BUDGET);
    wire        next_trip = tripped[ch] || fast_s[ch] || slow_hit;

    // Thresholds follow settings every cycle, no restart needed
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        thresh[ch] <= '0;
      end else begin
        thresh[ch].fast <= fast_th;
        thresh[ch].slow <= slow_th;
      end
    end

    // Short small overdrive leaks away before reaching the budget
    always_ff @(posedge clk) begin
      if (!rst_n || !chan_en[ch]) slow_acc[ch] <= 16'h0000;
      else if (over) slow_acc[ch] <= acc_sum[16] ? 16'hffff
                                                 : acc_sum[15:0];
      else if (slow_acc[ch] >= CBT_SLOW_LEAK)
        slow_acc[ch] <= slow_acc[ch] - CBT_SLOW_LEAK;
    end

    // Trip latches until the channel is disabled; gate and fault follow
    always_ff @(posedge clk) begin
      if (!rst_n || !chan_en[ch]) begin
        tripped[ch] <= 1'b0;
        gate_on[ch] <= 1'b0;
      end else begin
        tripped[ch] <= next_trip;
        gate_on[ch] <= !next_trip;
      end
    end

    // Open-drain fault: drive low while tripped, release otherwise
    assign fault_out[ch]  = 1'b0;
    assign fault_oe_n[ch] = !tripped[ch];

    // Checks
    fast_trip_gate_a: assert property (
      chan_en[ch] && $past(chan_en[ch]) && $past(fast_s[ch])
        |-> !gate_on[ch])
      else $error("gate stayed on after fast trip");
    quiet_gate_on_a: assert property (
      chan_en[ch] && !tripped[ch] && !fast_s[ch] && !slow_s[ch]
        |=> chan_en[ch] |-> gate_on[ch])
      else $error("gate off with no trip");
    fault_on_trip_a: assert property (
      tripped[ch] |-> !fault_oe_n[ch] && !gate_on[ch])
      else $error("trip without fault output");
    thresh_order_a: assert property (
      $past(rst_n, 2) |-> thresh[ch].fast > thresh[ch].slow)
      else $error("slow threshold not below fast");
    span_floor_a: assert property (
      fast_th >= 14'((22'(CBT_CODE_MIN) * 22'(fs_of(rng_c)))
                     / 22'(CBT_CODE_FULL)))
      else $error("fast threshold below span");
    sync_delay_a: assert property (
      $rose(fast_s[ch]) |-> $past(fast_cmp_async[ch], 2))
      else $error("fast trip not synchronised");
    slow_small_a: assert property (
      chan_en[ch] && slow_acc[ch] == 16'h0000 && !fast_s[ch]
        && !tripped[ch] && excess < SLOW_BUDGET |=> !tripped[ch])
      else $error("slow path tripped on small first overdrive");
    fault_pin_low_a: assert property (
      !fault_oe_n[ch] |-> !fault_in[ch])
      else $error("fault pin not low while driven");
  end

  // Register checks
  code_reset_a: assert property (
    $past(!rst_n) |-> code[0] == CBT_CODE_RST && code[1] == CBT_CODE_RST)
    else $error("code reset value wrong");
  ratio_reset_a: assert property (
    $past(!rst_n) |-> ratio_reg == CBT_RATIO_RST)
    else $error("ratio reset value wrong");
  range_write_a: assert property (
    wr_range |=> range_reg == $past(reg_req.wdata[3:0]))
    else $error("range write not applied");
  ratio_write_a: assert property (
    wr_ratio |=> ratio_reg[3:0] == $past(reg_req.wdata[3:0])
      && ratio_reg[7:4] == 4'h0)
    else $error("ratio write not applied");

endmodule

// >>> verif/cbt_load_model.sv
// Load model: sense resistor and pass switch for each channel.
// Assumes sense levels in 10 uV units and thresholds from the breaker.
`timescale 1ns/10ps
module cbt_load_model (
  // Breaker side
  input  wire logic [1:0]                gate_on,
  input  wire cbt_pkg::cbt_thresh_t [1:0] thresh,
  // Load demand while the switch conducts
  input  wire logic [1:0][13:0]          load,
  // Sense and comparator outputs
  output logic [1:0][13:0]               sense_level,
  output logic [1:0]                     fast_cmp,
  output logic [1:0]                     slow_cmp
);
  import cbt_pkg::*;

  // No current flows once the switch is off, so comparators fall too
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      sense_level[i] = gate_on[i] ? load[i] : 14'h0;
      fast_cmp[i]    = sense_level[i] > thresh[i].fast;
      slow_cmp[i]    = sense_level[i] > thresh[i].slow;
    end
  end
endmodule

// >>> verif/cbt_breaker_tb.sv
// Bench for the two-channel breaker: registers, thresholds and trips.
// Assumes the load model on the sense side and a pulled-up fault line.
`timescale 1ns/10ps
module cbt_breaker_tb;
  import cbt_pkg::*;
  logic              clk;
  logic              rst_n;
  cbt_reg_req_t      req;
  logic [7:0]        raddr;
  logic [7:0]        rdata;
  logic [1:0]        chan_en;
  logic [1:0][13:0]  sense;
  logic [1:0][13:0]  load;
  logic [1:0]        fast_cmp;
  logic [1:0]        slow_cmp;
  logic [1:0][1:0]   pins;
  cbt_thresh_t [1:0] thresh;
  logic [1:0]        gate_on;
  logic [1:0]        fault_out;
  logic [1:0]        fault_oe_n;
  logic [1:0]        fault_pin;
  int                err_count;
  int                compares;

  // Pull-up wins unless the breaker pulls the line low
  assign fault_pin = fault_oe_n | fault_out;

  // Short slow budget keeps slow trips within a few cycles
  cbt_breaker #(.NCH(2), .SLOW_BUDGET(16'h0010)) cbt_breaker_inst (
    .clk(clk), .rst_n(rst_n), .reg_req(req), .reg_raddr(raddr),
    .reg_rdata(rdata), .chan_en(chan_en), .sense_level(sense),
    .fast_cmp_async(fast_cmp), .slow_cmp_async(slow_cmp),
    .range_select_pin(pins), .thresh(thresh), .gate_on(gate_on),
    .fault_in(fault_pin), .fault_out(fault_out), .fault_oe_n(fault_oe_n)
  );

  cbt_load_model cbt_load_model_inst (
    .gate_on(gate_on), .thresh(thresh), .load(load),
    .sense_level(sense), .fast_cmp(fast_cmp), .slow_cmp(slow_cmp)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic give_verdict();
    if (err_count == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] got, exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s exp %h got %h", what, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // One-cycle write strobe, dropped at the next falling edge
  task automatic wr(input logic [7:0] a, d);
    @(negedge clk);
    req = '{1'b1, a, d};
    @(negedge clk);
    req.wr = 1'b0;
  endtask

  // Read data is registered, so it is looked at one cycle later
  task automatic rdchk(input string what, input logic [7:0] a, exp);
    @(negedge clk);
    raddr = a;
    @(negedge clk);
    chk(what, {8'h00, rdata}, {8'h00, exp});
  endtask

  function automatic int efast(input int code, input int rng);
    int fs;
    fs = (rng == 2) ? 2500 : (rng == 1) ? 5000 : 10000;
    if (code < 102) code = 102;
    return code * fs / 255;
  endfunction

  // Ratio code p stands for 125 + 25p percent
  task automatic thchk(input int ch, code, rng, p);
    int f;
    f = efast(code, rng);
    chk("fast", {2'h0, thresh[ch].fast}, 16'(f));
    chk("slow", {2'h0, thresh[ch].slow},
        16'(f * 100 / (125 + 25 * p)));
  endtask

  task automatic t_reset();
    rdchk("code0", CBT_OFF_CODE0, 8'hbf);
    rdchk("code1", CBT_OFF_CODE1, 8'hbf);
    rdchk("ratio", CBT_OFF_RATIO, 8'h0f);
    rdchk("range", CBT_OFF_RANGE, 8'h06);
    rdchk("unmapped", 8'h40, 8'h00);
    thchk(0, 'hbf, 2, 3);
    thchk(1, 'hbf, 1, 3);
  endtask

  task automatic t_ratio();
    for (int p = 0; p < 4; p++) begin
      wr(CBT_OFF_RATIO, 8'(5 * p));
      cyc(2);
      thchk(0, 'hbf, 2, p);
      thchk(1, 'hbf, 1, p);
    end
    wr(CBT_OFF_RATIO, 8'hf9);
    rdchk("ratio", CBT_OFF_RATIO, 8'h09);
    thchk(0, 'hbf, 2, 1);
    thchk(1, 'hbf, 1, 2);
    wr(CBT_OFF_RATIO, 8'h0f);
  endtask

  // Every range against codes below, at and above the usable floor
  task automatic t_range();
    int codes[3] = '{'h10, 'h66, 'hff};
    for (int r = 0; r < 3; r++) begin
      foreach (codes[k]) begin
        wr(CBT_OFF_RANGE, 8'(5 * r));
        wr(CBT_OFF_CODE0, 8'(codes[k]));
        wr(CBT_OFF_CODE1, 8'(codes[k]));
        cyc(2);
        thchk(0, codes[k], r, 3);
        thchk(1, codes[k], r, 3);
        rdchk("range", CBT_OFF_RANGE, 8'(5 * r));
      end
    end
  endtask

  // Channel 0: range 100 mV, code 0xff gives fast 10000, slow 5000
  task automatic t_fast();
    wr(CBT_OFF_RANGE, 8'h00);
    load[0] = 14'h0fa0;
    chan_en[0] = 1'b1;
    cyc(3);
    chk("gate0", {15'h0, gate_on[0]}, 16'h0001);
    chk("fault0", {15'h0, fault_pin[0]}, 16'h0001);
    load[0] = 14'h2711;
    cyc(4);
    chk("gate0", {15'h0, gate_on[0]}, 16'h0000);
    chk("fault0", {15'h0, fault_pin[0]}, 16'h0000);
    chan_en[0] = 1'b0;
  endtask

  // Channel 1: brief small overdrive rides through, a large one trips
  task automatic t_slow();
    wr(CBT_OFF_CODE1, 8'(5000 * 255 * 200 / 100 / 10000));
    load[1] = 14'h0fa0;
    chan_en[1] = 1'b1;
    cyc(3);
    chk("gate1", {15'h0, gate_on[1]}, 16'h0001);
    load[1] = 14'h1389;
    cyc(3);
    load[1] = 14'h0fa0;
    cyc(20);
    chk("gate1", {15'h0, gate_on[1]}, 16'h0001);
    load[1] = 14'h13ec;
    cyc(6);
    chk("gate1", {15'h0, gate_on[1]}, 16'h0000);
    chk("fault1", {15'h0, fault_pin[1]}, 16'h0000);
    chan_en[1] = 1'b0;
  endtask

  // Second reset: ch0 strapped high, ch1 left open; code 11 acts as 100 mV
  task automatic t_strap();
    @(negedge clk);
    pins = {2'h2, CBT_PIN_HIGH};
    rst_n = 1'b0;
    cyc(3);
    rst_n = 1'b1;
    cyc(6);
    rdchk("range", CBT_OFF_RANGE, 8'h01);
    rdchk("code0", CBT_OFF_CODE0, 8'hbf);
    thchk(0, 'hbf, 1, 3);
    thchk(1, 'hbf, 0, 3);
    wr(CBT_OFF_RANGE, 8'h0f);
    cyc(2);
    thchk(0, 'hbf, 3, 3);
  endtask

  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    #800000;
    err_count++;
    give_verdict();
  end

  initial begin
    err_count = 0;
    compares = 0;
    rst_n = 1'b0;
    req = '0;
    raddr = 8'h00;
    chan_en = 2'h0;
    load = '0;
    pins = {CBT_PIN_HIGH, CBT_PIN_LOW};
    cyc(10);
    rst_n = 1'b1;
    cyc(6);
    t_reset();
    t_ratio();
    t_range();
    t_fast();
    t_slow();
    t_strap();
    give_verdict();
  end
endmodule
